// >>> rtl/acld_pkg.sv
// constants, types and register map of the amplifier control and load diagnostics block
package acld_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ACLD_ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ACLD_ADDR_FAULT   = 8'h11;
  localparam logic [7:0] ACLD_ADDR_DIAG    = 8'h12;
  localparam logic [7:0] ACLD_ADDR_OPCTRL  = 8'h13;
  localparam logic [7:0] ACLD_ADDR_DIAGCTL = 8'h14;

  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [7:0] ACLD_OPCTRL_RST  = 8'h78;
  localparam logic [7:0] ACLD_DIAGCTL_RST = 8'h00;
  localparam int         ACLD_GAIN_MSB    = 7;
  localparam int         ACLD_GAIN_LSB    = 6;
  localparam int         ACLD_LIMIT_MSB   = 5;
  localparam int         ACLD_LIMIT_LSB   = 3;
  localparam int         ACLD_MUTE_BIT    = 2;
  localparam int         ACLD_SPREAD_BIT  = 1;
  localparam int         ACLD_FREQ_BIT    = 0;
  localparam int         ACLD_DISABLE_BIT = 0;
  localparam logic [2:0] ACLD_AGC_OFF     = 3'h7;

  // ----------------------------------------
  // gain codes in dB
  // ----------------------------------------
  localparam logic [5:0] ACLD_GAIN_DB0 = 6'h14;
  localparam logic [5:0] ACLD_GAIN_DB1 = 6'h1A;
  localparam logic [5:0] ACLD_GAIN_DB2 = 6'h20;
  localparam logic [5:0] ACLD_GAIN_DB3 = 6'h24;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int ACLD_CLK_HZ      = 20_000_000;
  localparam int ACLD_DIAG_MS     = 260;
  localparam int ACLD_DIAG_CYCLES = ACLD_CLK_HZ / 1000 * ACLD_DIAG_MS;

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  typedef enum logic [1:0] {
    ACLD_ST_IDLE = 2'b00,
    ACLD_ST_DIAG = 2'b01,
    ACLD_ST_PLAY = 2'b10,
    ACLD_ST_HOLD = 2'b11
  } acld_state_t;

endpackage : acld_pkg

// >>> rtl/acld_core.sv
// amplifier control registers and load diagnostic sequencer
`timescale 1ns/10ps

// Contract
// - two-bit gain field, four gain steps
// - three-bit power limit, code 111 disables AGC
// - control bit two mutes output
// - control bit one enables spread spectrum
// - control bit zero selects 400/500 kHz
// - diag control bit zero disables diagnostics
// - classify short ground/supply/load, open load
// - run diagnostics at power-up and faults
// - outputs high impedance during diagnostics
// - one run lasts about 260 ms
// - repeat check while short or capacitance
// - open load flagged, output still plays
// - shorts keep Hi-Z, rerun continuously
// - normal load enters play mode
// - diagnostics on every other overvoltage
// - OT, OV, UV abort running diagnostics
// - output duty cycles follow signal polarity; not done here, left to the analog stage
// - separate open, ground, supply flags
// - flags clear after condition gone, then read
// - diag result flags in bits 7 to 4
// - running flag set during diagnostic run
module acld_core
  import acld_pkg::*;
#(
  parameter int DIAG_CYCLES = acld_pkg::ACLD_DIAG_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port from the serial engine
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // protection events, analog side
  input  wire logic        fault_dc,
  input  wire logic        fault_oc,
  input  wire logic        fault_ov,
  input  wire logic        fault_uv,
  input  wire logic        fault_ot,
  // load sense comparators, analog side
  input  wire logic        sense_short_gnd,
  input  wire logic        sense_short_sup,
  input  wire logic        sense_short_load,
  input  wire logic        sense_open,
  input  wire logic        sense_big_cap,
  // amplifier controls
  output logic      [1:0]  gain_select,
  output logic      [2:0]  power_limit_select,
  output logic             agc_enable,
  output logic             soft_mute,
  output logic             spread_spectrum_enable,
  output logic             switch_freq_select,
  output logic             out_hiz,
  output logic             play_mode,
  output logic             diag_running_flag
);
  import acld_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  opctrl;
    logic [7:0]  diagctl;
    logic [3:0]  flags;     // shorted load, open, ground, supply
    logic [3:0]  seen;      // condition still present
    logic [4:0]  fsync1;
    logic [4:0]  fsync2;
    logic [4:0]  fprev;
    logic [4:0]  ssync1;
    logic [4:0]  ssync2;
    logic        ov_odd;
    acld_state_t st;
    logic [23:0] cnt;
    logic [7:0]  rdata;
    // output flops, kept in step with the state
    logic        agc_on;
    logic        hiz;
    logic        play;
    logic        running;
  } acld_s_t;

  acld_s_t q_reg;
  acld_s_t q_next;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [5:0] acld_gain_db(input logic [1:0] code);
    case (code)
      2'b00:   acld_gain_db = ACLD_GAIN_DB0;
      2'b01:   acld_gain_db = ACLD_GAIN_DB1;
      2'b10:   acld_gain_db = ACLD_GAIN_DB2;
      default: acld_gain_db = ACLD_GAIN_DB3;
    endcase
  endfunction : acld_gain_db

  // new fault edge starts a run, overvoltage only on odd events
  function automatic logic acld_trigger(input logic [4:0] rise, input logic ov_skip);
    logic ov_hit;
    ov_hit       = rise[2] & ~ov_skip;
    acld_trigger = rise[4] | rise[3] | rise[1] | rise[0] | ov_hit;
  endfunction : acld_trigger

  // protection faults that cut a run short
  function automatic logic acld_abort(input logic [4:0] lvl);
    acld_abort = lvl[2] | lvl[1] | lvl[0];
  endfunction : acld_abort

  // status byte: play, mute, running, any fault, low nibble zero
  function automatic logic [7:0] acld_status(input acld_state_t s, input logic mute,
                                             input logic [4:0] lvl);
    acld_status = {s == ACLD_ST_PLAY, mute, s == ACLD_ST_DIAG, |lvl, 4'h0};
  endfunction : acld_status

  // read multiplexer, unmapped and unimplemented offsets read zero
  function automatic logic [7:0] acld_read(input logic [7:0] addr, input logic [7:0] stat,
                                           input logic [3:0] flg, input logic [7:0] op,
                                           input logic [7:0] dctl);
    if (addr == ACLD_ADDR_STATUS) begin
      acld_read = stat;
    end else if (addr == ACLD_ADDR_DIAG) begin
      acld_read = {flg, 4'h0};
    end else if (addr == ACLD_ADDR_OPCTRL) begin
      acld_read = op;
    end else if (addr == ACLD_ADDR_DIAGCTL) begin
      acld_read = dctl;
    end else begin
      acld_read = 8'h00;
    end
  endfunction : acld_read

  // a read drops what the last finished run no longer saw;
  // findings of a finishing run are ORed in last, so the set wins
  function automatic logic [3:0] acld_flags(input logic [3:0] cur, input logic [3:0] still,
                                            input logic rd_clr, input logic done,
                                            input logic [3:0] now);
    logic [3:0] kept;
    kept       = rd_clr ? (cur & still) : cur;
    acld_flags = done ? (kept | now) : kept;
  endfunction : acld_flags

  logic [4:0] frise;
  logic       ov_rise;
  logic       trig;
  logic       abort;
  logic       any_short;
  logic [3:0] found;
  logic       unused_gain;
  logic       rd_hit;
  logic       run_done;
  logic [7:0] status;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    q_next        = q_reg;

    // ----------------------------------------
    // input synchronisers, two flops each
    // ----------------------------------------
    q_next.fsync1 = {fault_dc, fault_oc, fault_ov, fault_uv, fault_ot};
    q_next.fsync2 = q_reg.fsync1;
    q_next.fprev  = q_reg.fsync2;
    q_next.ssync1 = {sense_short_load, sense_open, sense_short_gnd, sense_short_sup,
                     sense_big_cap};
    q_next.ssync2 = q_reg.ssync1;

    // ----------------------------------------
    // event decode
    // ----------------------------------------
    // abort looks at levels, triggers at edges
    frise       = q_reg.fsync2 & ~q_reg.fprev;
    ov_rise     = frise[2];
    found       = q_reg.ssync2[4:1];
    any_short   = found[3] | found[1] | found[0];
    unused_gain = ^acld_gain_db(q_reg.opctrl[ACLD_GAIN_MSB:ACLD_GAIN_LSB]);
    // every second overvoltage is skipped
    if (ov_rise) begin
      q_next.ov_odd = ~q_reg.ov_odd;
    end
    trig     = acld_trigger(frise, q_reg.ov_odd);
    abort    = acld_abort(q_reg.fsync2);
    rd_hit   = reg_rd && reg_addr == ACLD_ADDR_DIAG;
    run_done = q_reg.st == ACLD_ST_DIAG && !abort && q_reg.cnt == 24'(DIAG_CYCLES - 1);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    case (q_reg.st)
      ACLD_ST_IDLE: begin
        q_next.cnt = '0;
        if (!q_reg.diagctl[ACLD_DISABLE_BIT]) begin
          q_next.st = ACLD_ST_DIAG;
        end else begin
          q_next.st = ACLD_ST_PLAY;
        end
      end
      ACLD_ST_DIAG: begin
        q_next.cnt = q_reg.cnt + 24'h000001;
        if (abort) begin
          q_next.st  = ACLD_ST_HOLD;
          q_next.cnt = '0;
        end else if (run_done) begin
          q_next.cnt  = '0;
          q_next.seen = found;
          if (any_short || q_reg.ssync2[0]) begin
            q_next.st = ACLD_ST_DIAG;
          end else begin
            q_next.st = ACLD_ST_PLAY;
          end
        end
      end
      ACLD_ST_PLAY: begin
        q_next.cnt = '0;
        if (trig && !q_reg.diagctl[ACLD_DISABLE_BIT]) begin
          q_next.st = ACLD_ST_HOLD;
        end
      end
      default: begin
        // wait for the protection fault to clear, then diagnose again
        q_next.cnt = '0;
        if (!(|q_reg.fsync2)) begin
          q_next.st = ACLD_ST_IDLE;
        end
      end
    endcase

    // ----------------------------------------
    // result flags
    // ----------------------------------------
    q_next.flags = acld_flags(q_reg.flags, q_reg.seen, rd_hit, run_done, found);

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // read-only and unmapped offsets ignore writes
    if (reg_wr) begin
      if (reg_addr == ACLD_ADDR_OPCTRL) begin
        q_next.opctrl = reg_wdata;
      end else if (reg_addr == ACLD_ADDR_DIAGCTL) begin
        q_next.diagctl = {7'h00, reg_wdata[ACLD_DISABLE_BIT]};
      end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    status       = acld_status(q_reg.st, q_reg.opctrl[ACLD_MUTE_BIT], q_reg.fsync2);
    q_next.rdata = acld_read(reg_addr, status, q_reg.flags, q_reg.opctrl, q_reg.diagctl);

    // ----------------------------------------
    // output flops
    // ----------------------------------------
    q_next.agc_on  = q_next.opctrl[ACLD_LIMIT_MSB:ACLD_LIMIT_LSB] != ACLD_AGC_OFF;
    q_next.hiz     = q_next.st != ACLD_ST_PLAY;
    q_next.play    = q_next.st == ACLD_ST_PLAY;
    q_next.running = q_next.st == ACLD_ST_DIAG;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg         <= '0;
      q_reg.opctrl  <= ACLD_OPCTRL_RST;
      q_reg.diagctl <= ACLD_DIAGCTL_RST;
      q_reg.st      <= ACLD_ST_IDLE;
      // outputs come up released and not playing
      q_reg.hiz     <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // ----------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------
  // duty-cycle steering of the modulator lives in the analog stage
  assign reg_rdata              = q_reg.rdata;
  assign gain_select            = q_reg.opctrl[ACLD_GAIN_MSB:ACLD_GAIN_LSB];
  assign power_limit_select     = q_reg.opctrl[ACLD_LIMIT_MSB:ACLD_LIMIT_LSB];
  assign agc_enable             = q_reg.agc_on;
  assign soft_mute              = q_reg.opctrl[ACLD_MUTE_BIT];
  assign spread_spectrum_enable = q_reg.opctrl[ACLD_SPREAD_BIT];
  assign switch_freq_select     = q_reg.opctrl[ACLD_FREQ_BIT];
  assign out_hiz                = q_reg.hiz;
  assign play_mode              = q_reg.play;
  assign diag_running_flag      = q_reg.running;

endmodule : acld_core

// >>> testbench/acld_chk.sv
// concurrent checks on the amplifier control and load diagnostics ports
`timescale 1ns/10ps
module acld_chk
  import acld_pkg::*;
#(
  parameter int DIAG_CYCLES = 20
) (
  input wire logic       clk, rst_n, reg_wr, fault_ov, fault_uv, fault_ot,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [1:0] gain_select,
  input wire logic [2:0] power_limit_select,
  input wire logic       agc_enable, soft_mute, spread_spectrum_enable, switch_freq_select,
  input wire logic       out_hiz, play_mode, diag_running_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // length of the latest diagnostic run
  int   run_cnt;
  logic run_on;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_cnt <= 0;
      run_on  <= 1'b0;
    end else begin
      run_on  <= diag_running_flag;
      run_cnt <= diag_running_flag ? (run_on ? run_cnt + 1 : 1) : run_cnt;
    end
  end
  sequence op_wr; reg_wr && reg_addr == ACLD_ADDR_OPCTRL; endsequence
  sequence prot_on; (fault_ot || fault_ov || fault_uv) [*3]; endsequence
  AST_GAIN: assert property (op_wr |=> gain_select == $past(reg_wdata[7:6]))
    else $error("gain field not applied");
  AST_LIMIT: assert property (op_wr |=> power_limit_select == $past(reg_wdata[5:3]))
    else $error("limit field not applied");
  AST_AGC: assert property (agc_enable == (power_limit_select != ACLD_AGC_OFF))
    else $error("agc enable wrong");
  AST_CTRL: assert property (op_wr |=> {soft_mute, spread_spectrum_enable,
    switch_freq_select} == $past(reg_wdata[2:0]))
    else $error("control bits not applied");
  AST_HIZ_DIAG: assert property (diag_running_flag |-> out_hiz && !play_mode)
    else $error("outputs driven during diagnostics");
  AST_PLAY_DRIVE: assert property (play_mode |-> !out_hiz)
    else $error("play without driving outputs");
  AST_RUN_LEN: assert property ($rose(play_mode) |-> run_cnt >= DIAG_CYCLES - 2)
    else $error("diagnostic run too short");
  AST_DIAG_PAD: assert property (reg_addr == ACLD_ADDR_DIAG |=> reg_rdata[3:0] == 4'h0)
    else $error("result low bits not zero");
  AST_CTL_PAD: assert property (reg_addr == ACLD_ADDR_DIAGCTL |=> reg_rdata[7:1] == 7'h00)
    else $error("diag control upper bits not zero");
  AST_ABORT: assert property (diag_running_flag ##0 prot_on |-> ##[0:4] !diag_running_flag)
    else $error("run not aborted by protection fault");
endmodule : acld_chk
bind acld_core acld_chk #(.DIAG_CYCLES(DIAG_CYCLES)) chk_u (.*);

// >>> testbench/acld_host.sv
// register-port host model
`timescale 1ns/10ps
module acld_host (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'hFF;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : rd
endmodule : acld_host

// >>> testbench/amp_control_and_load_diag_bench.sv
// self-checking bench for amplifier control and load diagnostics
`timescale 1ns/10ps
module amp_control_and_load_diag_bench;
  import acld_pkg::*;
  localparam int DC = 20;
  logic clk, rst_n, reg_wr, reg_rd, rd_d, agc_enable, soft_mute, spread_spectrum_enable;
  logic switch_freq_select, out_hiz, play_mode, diag_running_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [1:0] gain_select;
  logic [2:0] power_limit_select;
  logic [4:0] flt, sns;
  logic [7:0] exp_q[$];
  int n_errors, samples_checked, cyc;
  acld_core #(.DIAG_CYCLES(DC)) dut_u (.fault_dc(flt[0]), .fault_oc(flt[1]),
    .fault_ov(flt[2]), .fault_uv(flt[3]), .fault_ot(flt[4]), .sense_short_gnd(sns[0]),
    .sense_short_sup(sns[1]), .sense_short_load(sns[2]), .sense_open(sns[3]),
    .sense_big_cap(sns[4]), .*);
  acld_host host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.rd(a);
  endtask : rd_exp
  task automatic wait_play();
    for (int i = 0; i < 200 && play_mode !== 1'b1; i++) @(posedge clk);
    check("play", {play_mode, out_hiz}, 2'b10);
  endtask : wait_play
  task automatic fault_pulse(input int b);
    @(posedge clk);
    flt[b] <= 1'b1;
    repeat (4) @(posedge clk);
    flt[b] <= 1'b0;
  endtask : fault_pulse
  // read data monitor against the expected queue
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) check("rdata", reg_rdata, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    flt = 5'h00;
    sns = 5'h00;
    void'($urandom(32'hA2DE));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("run", {diag_running_flag, out_hiz, play_mode}, 3'b110);
    rd_exp(ACLD_ADDR_OPCTRL, ACLD_OPCTRL_RST);
    rd_exp(ACLD_ADDR_DIAGCTL, ACLD_DIAGCTL_RST);
    check("agc", agc_enable, 1'b0);
    wait_play();
    check("run", diag_running_flag, 1'b0);
    host_u.wr(ACLD_ADDR_DIAG, 8'hFF);
    rd_exp(ACLD_ADDR_DIAG, 8'h00);
    rd_exp(8'h20, 8'h00);
    for (int g = 0; g < 8; g++) begin
      v = 8'($urandom);
      v[5:3] = g[2:0];
      v[7:6] = g[1:0];
      host_u.wr(ACLD_ADDR_OPCTRL, v);
      @(negedge clk);
      check("ctl", {gain_select, power_limit_select, soft_mute, spread_spectrum_enable,
        switch_freq_select}, v);
      check("agc", agc_enable, v[5:3] != 3'h7);
      rd_exp(ACLD_ADDR_OPCTRL, v);
    end
    host_u.wr(ACLD_ADDR_DIAGCTL, 8'hFF);
    rd_exp(ACLD_ADDR_DIAGCTL, 8'h01);
    fault_pulse(0);
    repeat (6) @(posedge clk);
    check("skip", {play_mode, diag_running_flag}, 2'b10);
    host_u.wr(ACLD_ADDR_DIAGCTL, 8'h00);
    sns <= 5'b01000;
    fault_pulse(1);
    wait_play();
    rd_exp(ACLD_ADDR_DIAG, 8'h40);
    sns <= 5'b00000;
    fault_pulse(1);
    wait_play();
    rd_exp(ACLD_ADDR_DIAG, 8'h40);
    rd_exp(ACLD_ADDR_DIAG, 8'h00);
    sns <= 5'b00001;
    fault_pulse(2);
    repeat (DC * 5) @(posedge clk);
    check("hold", {play_mode, out_hiz}, 2'b01);
    rd_exp(ACLD_ADDR_DIAG, 8'h20);
    sns <= 5'b00000;
    wait_play();
    rd_exp(ACLD_ADDR_DIAG, 8'h20);
    fault_pulse(2);
    repeat (4) @(posedge clk);
    check("ov", {play_mode, diag_running_flag}, 2'b10);
    sns <= 5'b00100;
    fault_pulse(0);
    repeat (6) @(posedge clk);
    flt[4] <= 1'b1;
    repeat (6) @(posedge clk);
    check("abort", {diag_running_flag, out_hiz}, 2'b01);
    sns <= 5'b00000;
    flt[4] <= 1'b0;
    wait_play();
    rd_exp(ACLD_ADDR_DIAG, 8'h00);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule : amp_control_and_load_diag_bench
